/* rtl/csio_pkg.sv */
package csio_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 13;
    localparam logic [12:0] ADDR_RX_BG     = 13'h001a;
    localparam logic [12:0] ADDR_CRYSTAL_INPUT      = 13'h001b;
    localparam logic [12:0] ADDR_SPARE     = 13'h001c;
    localparam logic [12:0] ADDR_REF       = 13'h001d;
    localparam logic [12:0] ADDR_DRV       = 13'h0032;

    localparam logic [7:0]  RST_RX_BG      = 8'h00;
    localparam logic [7:0]  RST_CRYSTAL_INPUT       = 8'h80;
    localparam logic [7:0]  RST_REF        = 8'h00;
    localparam logic [7:0]  RST_DRV        = 8'ha8;
    // Driver image: strong, active, LVPECL, both pins driven, no inversion
    localparam logic [8:0]  RST_DRV_OUT    = 9'h15c;

    // Writable bits of each register; the rest read as zero
    localparam logic [7:0]  MASK_RX_BG     = 8'hfd;
    localparam logic [7:0]  MASK_CRYSTAL_INPUT      = 8'hbf;
    localparam logic [7:0]  MASK_REF       = 8'h05;
    localparam logic [7:0]  MASK_DRV       = 8'hff;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RX_RESET_BIT   = 7;
    localparam int BG_MSB         = 6;
    localparam int BG_LSB         = 2;
    localparam int BG_SPI_BIT     = 0;
    localparam int CRYSTAL_INPUT_AUTO_BIT  = 7;
    localparam int CRYSTAL_INPUT_CAP_MSB   = 5;
    localparam int REF_DBL_BIT    = 2;
    localparam int REF_CRYSTAL_INPUT_BIT   = 0;
    localparam int DRV_STRONG_BIT = 7;
    localparam int DRV_PD_BIT     = 6;
    localparam int DRV_FMT_MSB    = 5;
    localparam int DRV_FMT_LSB    = 3;
    localparam int DRV_POL_MSB    = 2;
    localparam int DRV_POL_LSB    = 1;
    localparam int DRV_SPI_BIT    = 0;

    // ------------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------------
    localparam logic [4:0] INSTR_LAST = 5'h0f;
    localparam logic [4:0] DATA_LAST  = 5'h07;
    localparam int         RD_FLAG_BIT = 14;

    typedef enum logic [2:0] {
        FMT_CMOS_BOTH = 3'b000,
        FMT_CMOS_POS  = 3'b001,
        FMT_CMOS_NEG  = 3'b010,
        FMT_CMOS_OFF  = 3'b011,
        FMT_LVDS      = 3'b100,
        FMT_LVPECL    = 3'b101,
        FMT_UNUSED6   = 3'b110,
        FMT_UNUSED7   = 3'b111
    } csio_fmt_t;

    typedef enum logic [2:0] {
        SP_IDLE  = 3'b000,
        SP_INSTR = 3'b001,
        SP_WDATA = 3'b010,
        SP_RLOAD = 3'b011,
        SP_RDATA = 3'b100,
        SP_DONE  = 3'b101
    } csio_sp_st_t;

endpackage

/* rtl/csio_serial_port.sv */
`timescale 1ns/1ps
module csio_serial_port (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        sdio_in,
    input  wire logic [7:0]  rd_data_in,
    output logic             sdio_out,
    output logic             sdio_oe_out,
    output logic             wr_stb_out,
    output logic [12:0]      addr_out,
    output logic [7:0]       wr_data_out
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0]          sclk_sync_reg;
    logic [1:0]          cs_n_sync_reg;
    logic [1:0]          sdio_sync_reg;
    logic                sclk_prev_reg;
    logic                sclk_rise;
    logic                cs_active;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_sync_reg <= 2'h0;
            cs_n_sync_reg <= 2'h3;
            sdio_sync_reg <= 2'h0;
            sclk_prev_reg <= 1'b0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
            cs_n_sync_reg <= {cs_n_sync_reg[0], cs_n_in};
            sdio_sync_reg <= {sdio_sync_reg[0], sdio_in};
            sclk_prev_reg <= sclk_sync_reg[1];
        end
    end

    assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
    assign cs_active = ~cs_n_sync_reg[1];

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    csio_pkg::csio_sp_st_t st_reg,      st_next;
    logic [4:0]            cnt_reg,     cnt_next;
    logic [15:0]           shift_reg,   shift_next;
    logic [7:0]            rd_sh_reg,   rd_sh_next;
    logic [12:0]           addr_reg,    addr_next;
    logic [7:0]            wdata_reg,   wdata_next;
    logic                  oe_reg,      oe_next;
    logic                  wr_stb_reg,  wr_stb_next;

    always_comb begin
        st_next     = st_reg;
        cnt_next    = cnt_reg;
        shift_next  = shift_reg;
        rd_sh_next  = rd_sh_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        oe_next     = oe_reg;
        wr_stb_next = 1'b0;
        if (!cs_active) begin
            st_next  = csio_pkg::SP_IDLE;
            cnt_next = 5'h00;
            oe_next  = 1'b0;
        end else begin
            unique case (st_reg)
                csio_pkg::SP_IDLE: begin
                    st_next  = csio_pkg::SP_INSTR;
                    cnt_next = 5'h00;
                end
                csio_pkg::SP_INSTR: if (sclk_rise) begin
                    shift_next = {shift_reg[14:0], sdio_sync_reg[1]};
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == csio_pkg::INSTR_LAST) begin
                        addr_next = {shift_reg[11:0], sdio_sync_reg[1]};
                        cnt_next  = 5'h00;
                        st_next   = shift_reg[csio_pkg::RD_FLAG_BIT] ? csio_pkg::SP_RLOAD
                                                                     : csio_pkg::SP_WDATA;
                    end
                end
                csio_pkg::SP_WDATA: if (sclk_rise) begin
                    shift_next = {shift_reg[14:0], sdio_sync_reg[1]};
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == csio_pkg::DATA_LAST) begin
                        wdata_next  = {shift_reg[6:0], sdio_sync_reg[1]};
                        wr_stb_next = 1'b1;
                        st_next     = csio_pkg::SP_DONE;
                    end
                end
                csio_pkg::SP_RLOAD: begin
                    rd_sh_next = rd_data_in;
                    oe_next    = 1'b1;
                    st_next    = csio_pkg::SP_RDATA;
                end
                csio_pkg::SP_RDATA: if (sclk_rise) begin
                    rd_sh_next = {rd_sh_reg[6:0], 1'b0};
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == csio_pkg::DATA_LAST) begin
                        oe_next = 1'b0;
                        st_next = csio_pkg::SP_DONE;
                    end
                end
                csio_pkg::SP_DONE: st_next = csio_pkg::SP_DONE;
                default:           st_next = csio_pkg::SP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_reg     <= csio_pkg::SP_IDLE;
            cnt_reg    <= 5'h00;
            shift_reg  <= 16'h0000;
            rd_sh_reg  <= 8'h00;
            addr_reg   <= 13'h0000;
            wdata_reg  <= 8'h00;
            oe_reg     <= 1'b0;
            wr_stb_reg <= 1'b0;
        end else begin
            st_reg     <= st_next;
            cnt_reg    <= cnt_next;
            shift_reg  <= shift_next;
            rd_sh_reg  <= rd_sh_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            oe_reg     <= oe_next;
            wr_stb_reg <= wr_stb_next;
        end
    end

    assign sdio_out    = rd_sh_reg[7];
    assign sdio_oe_out = oe_reg;
    assign wr_stb_out  = wr_stb_reg;
    assign addr_out    = addr_reg;
    assign wr_data_out = wdata_reg;

endmodule // csio_serial_port

/* rtl/csio_drv_decode.sv */
`timescale 1ns/1ps
module csio_drv_decode (
    input  wire logic [7:0]  ctrl_in,
    input  wire logic        fmt_pin_in,
    output logic             strong_out,
    output logic             pd_out,
    output logic [2:0]       fmt_out,
    output logic             pos_en_out,
    output logic             neg_en_out,
    output logic             pos_inv_out,
    output logic             neg_inv_out
);

    csio_pkg::csio_fmt_t fmt;
    logic [1:0]          pol;

    always_comb begin
        if (ctrl_in[csio_pkg::DRV_SPI_BIT]) begin
            strong_out = ctrl_in[csio_pkg::DRV_STRONG_BIT];
            pd_out     = ctrl_in[csio_pkg::DRV_PD_BIT];
            fmt = csio_pkg::csio_fmt_t'(ctrl_in[csio_pkg::DRV_FMT_MSB:csio_pkg::DRV_FMT_LSB]);
            pol = ctrl_in[csio_pkg::DRV_POL_MSB:csio_pkg::DRV_POL_LSB];
        end else begin
            // Pin mode: differential format from the pin, other bits at default
            strong_out = 1'b1;
            pd_out     = 1'b0;
            fmt = fmt_pin_in ? csio_pkg::FMT_LVPECL : csio_pkg::FMT_LVDS;
            pol = 2'h0;
        end
        pos_en_out = 1'b0;
        neg_en_out = 1'b0;
        unique case (fmt)
            csio_pkg::FMT_CMOS_BOTH: begin
                pos_en_out = 1'b1;
                neg_en_out = 1'b1;
            end
            csio_pkg::FMT_CMOS_POS:  pos_en_out = 1'b1;
            csio_pkg::FMT_CMOS_NEG:  neg_en_out = 1'b1;
            csio_pkg::FMT_CMOS_OFF:  pos_en_out = 1'b0;
            csio_pkg::FMT_LVDS, csio_pkg::FMT_LVPECL: begin
                pos_en_out = 1'b1;
                neg_en_out = 1'b1;
            end
            csio_pkg::FMT_UNUSED6, csio_pkg::FMT_UNUSED7: pos_en_out = 1'b0;
        endcase
        fmt_out = fmt;
        // Polarity only acts in CMOS formats
        pos_inv_out = ~fmt[2] & pol[1];
        neg_inv_out = ~fmt[2] & ~pol[0];
    end

endmodule // csio_drv_decode

/* rtl/csio_config_top.sv */
`timescale 1ns/1ps
// How it works
// - Writing one to receiver reset bit 7 pulses receiver reset, then bit self-clears.
// - Five-bit band gap adjust field in bits 6:2, resets to zero.
// - Bit 0 low selects automatic band gap; high applies the adjust field.
// - Crystal register bit 7 high (reset) selects automatic tuning; low uses field.
// - Six-bit tuning field is inverted binary, 0.25 pF per step; zero is 15.75 pF.
// - Reference path bit 2 low bypasses the doubler; high inserts it.
// - Reference bit 0 low follows detected external reference; high forces crystal input.
// - Driver bit 7 selects weak (0) or strong (1) drive; strong after reset.
// - Driver bit 6 low keeps primary output active; high powers it down.
// - Format field 5:3 selects CMOS variants, LVDS or LVPECL; LVPECL after reset.
// - Polarity field 2:1 sets sense of each CMOS pin; 00 after reset.
// - Polarity field is ignored in non-CMOS formats.
// - Driver bit 0 low: format pin picks LVDS/LVPECL; high: bits 7:1 govern.
module csio_config_top (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        sdio_in,
    output logic             sdio_out,
    output logic             sdio_oe_out,
    input  wire logic        output_format_select_pin_in,
    input  wire logic        ext_ref_present_in,
    output logic             rx_reset_out,
    output logic             bandgap_spi_en_out,
    output logic [4:0]       bandgap_code_out,
    output logic             crystal_input_cap_auto_out,
    output logic [5:0]       crystal_input_cap_quarter_pf_out,
    output logic             doubler_sel_out,
    output logic             use_ext_ref_out,
    output logic             primary_output_strong_out,
    output logic             primary_output_pd_out,
    output logic [2:0]       primary_output_fmt_out,
    output logic             primary_output_pos_en_out,
    output logic             primary_output_neg_en_out,
    output logic             primary_output_pos_inv_out,
    output logic             primary_output_neg_inv_out
);

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    logic        wr_stb;
    logic [12:0] addr;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;

    csio_serial_port u_port (
        .clk_sys_in  (clk_sys_in),
        .rst_in      (rst_in),
        .sclk_in     (sclk_in),
        .cs_n_in     (cs_n_in),
        .sdio_in     (sdio_in),
        .rd_data_in  (rd_data),
        .sdio_out    (sdio_out),
        .sdio_oe_out (sdio_oe_out),
        .wr_stb_out  (wr_stb),
        .addr_out    (addr),
        .wr_data_out (wr_data)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [1:0] fmt_pin_sync_reg;
    logic [1:0] ext_ref_sync_reg;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            fmt_pin_sync_reg <= 2'h0;
            ext_ref_sync_reg <= 2'h0;
        end else begin
            fmt_pin_sync_reg <= {fmt_pin_sync_reg[0], output_format_select_pin_in};
            ext_ref_sync_reg <= {ext_ref_sync_reg[0], ext_ref_present_in};
        end
    end

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    logic [7:0] rx_bg_reg, rx_bg_next;
    logic [7:0] crystal_input_reg,  crystal_input_next;
    logic [7:0] ref_reg,   ref_next;
    logic [7:0] drv_reg,   drv_next;

    always_comb begin
        // Receiver reset clears itself one cycle after being set
        rx_bg_next = rx_bg_reg;
        rx_bg_next[csio_pkg::RX_RESET_BIT] = 1'b0;
        crystal_input_next  = crystal_input_reg;
        ref_next   = ref_reg;
        drv_next   = drv_reg;
        if (wr_stb) begin
            // A write overrides the self-clear, so a new reset is never lost
            unique case (addr)
                csio_pkg::ADDR_RX_BG: rx_bg_next = wr_data & csio_pkg::MASK_RX_BG;
                csio_pkg::ADDR_CRYSTAL_INPUT:  crystal_input_next  = wr_data & csio_pkg::MASK_CRYSTAL_INPUT;
                csio_pkg::ADDR_REF:   ref_next   = wr_data & csio_pkg::MASK_REF;
                csio_pkg::ADDR_DRV:   drv_next   = wr_data & csio_pkg::MASK_DRV;
                default:              rx_bg_next = rx_bg_next;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rx_bg_reg <= csio_pkg::RST_RX_BG;
            crystal_input_reg  <= csio_pkg::RST_CRYSTAL_INPUT;
            ref_reg   <= csio_pkg::RST_REF;
            drv_reg   <= csio_pkg::RST_DRV;
        end else begin
            rx_bg_reg <= rx_bg_next;
            crystal_input_reg  <= crystal_input_next;
            ref_reg   <= ref_next;
            drv_reg   <= drv_next;
        end
    end

    // Unmapped addresses and the spare register read zero
    always_comb begin
        unique case (addr)
            csio_pkg::ADDR_RX_BG: rd_data = rx_bg_reg;
            csio_pkg::ADDR_CRYSTAL_INPUT:  rd_data = crystal_input_reg;
            csio_pkg::ADDR_REF:   rd_data = ref_reg;
            csio_pkg::ADDR_DRV:   rd_data = drv_reg;
            default:              rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Reference and receiver controls
    // ------------------------------------------------------------------
    logic use_ext_reg, use_ext_next;

    always_comb begin
        use_ext_next = ext_ref_sync_reg[1] & ~ref_reg[csio_pkg::REF_CRYSTAL_INPUT_BIT];
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            use_ext_reg <= 1'b0;
        end else begin
            use_ext_reg <= use_ext_next;
        end
    end

    assign rx_reset_out            = rx_bg_reg[csio_pkg::RX_RESET_BIT];
    assign bandgap_spi_en_out      = rx_bg_reg[csio_pkg::BG_SPI_BIT];
    assign bandgap_code_out        = rx_bg_reg[csio_pkg::BG_SPI_BIT]
                                   ? rx_bg_reg[csio_pkg::BG_MSB:csio_pkg::BG_LSB] : 5'h00;
    assign crystal_input_cap_auto_out       = crystal_input_reg[csio_pkg::CRYSTAL_INPUT_AUTO_BIT];
    assign crystal_input_cap_quarter_pf_out = ~crystal_input_reg[csio_pkg::CRYSTAL_INPUT_CAP_MSB:0];
    assign doubler_sel_out         = ref_reg[csio_pkg::REF_DBL_BIT];
    assign use_ext_ref_out         = use_ext_reg;

    // ------------------------------------------------------------------
    // Primary output driver
    // ------------------------------------------------------------------
    logic       dec_strong, dec_pd, dec_pos_en, dec_neg_en, dec_pos_inv, dec_neg_inv;
    logic [2:0] dec_fmt;
    logic [8:0] drv_out_reg, drv_out_next;

    csio_drv_decode u_decode (
        .ctrl_in     (drv_reg),
        .fmt_pin_in  (fmt_pin_sync_reg[1]),
        .strong_out  (dec_strong),
        .pd_out      (dec_pd),
        .fmt_out     (dec_fmt),
        .pos_en_out  (dec_pos_en),
        .neg_en_out  (dec_neg_en),
        .pos_inv_out (dec_pos_inv),
        .neg_inv_out (dec_neg_inv)
    );

    always_comb begin
        drv_out_next = {dec_strong, dec_pd, dec_fmt, dec_pos_en, dec_neg_en,
                        dec_pos_inv, dec_neg_inv};
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            drv_out_reg <= csio_pkg::RST_DRV_OUT;
        end else begin
            drv_out_reg <= drv_out_next;
        end
    end

    assign primary_output_strong_out  = drv_out_reg[8];
    assign primary_output_pd_out      = drv_out_reg[7];
    assign primary_output_fmt_out     = drv_out_reg[6:4];
    assign primary_output_pos_en_out  = drv_out_reg[3];
    assign primary_output_neg_en_out  = drv_out_reg[2];
    assign primary_output_pos_inv_out = drv_out_reg[1];
    assign primary_output_neg_inv_out = drv_out_reg[0];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_rx_reset_pulse: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        rx_reset_out |=> !rx_reset_out)
        else $error("receiver reset did not clear itself");

    a_rx_reset_cause: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_stb && addr == csio_pkg::ADDR_RX_BG && wr_data[7]) |=> rx_reset_out ##1 !rx_reset_out)
        else $error("receiver reset pulse wrong after write");

    a_bandgap_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_stb && addr == csio_pkg::ADDR_RX_BG && wr_data[0])
        |=> bandgap_code_out == $past(wr_data[6:2]) && bandgap_spi_en_out)
        else $error("band gap field not applied");

    a_bandgap_auto: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !bandgap_spi_en_out |-> bandgap_code_out == 5'h00)
        else $error("band gap code driven in automatic mode");

    a_crystal_input_decode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_stb && addr == csio_pkg::ADDR_CRYSTAL_INPUT)
        |=> crystal_input_cap_quarter_pf_out == ~$past(wr_data[5:0])
            && crystal_input_cap_auto_out == $past(wr_data[7]))
        else $error("crystal tuning decode wrong");

    a_doubler_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_stb && addr == csio_pkg::ADDR_REF) |=> doubler_sel_out == $past(wr_data[2]))
        else $error("doubler select not updated");

    a_ref_forced: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ref_reg[0] ##1 ref_reg[0] |-> !use_ext_ref_out)
        else $error("external reference used while crystal forced");

    a_drv_pd_write: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (wr_stb && addr == csio_pkg::ADDR_DRV && wr_data[0])
        |=> ##1 primary_output_pd_out == $past(wr_data[6], 2)
            && primary_output_strong_out == $past(wr_data[7], 2))
        else $error("driver power-down or strength not applied");

    a_drv_pin_mode: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $past(!drv_reg[0]) |-> primary_output_strong_out && !primary_output_pd_out
            && primary_output_fmt_out[2:1] == 2'h2)
        else $error("pin mode format not differential");

    a_pol_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        primary_output_fmt_out[2] |-> !primary_output_pos_inv_out && !primary_output_neg_inv_out)
        else $error("polarity applied outside CMOS");

    a_spare_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        addr == csio_pkg::ADDR_SPARE |-> rd_data == 8'h00)
        else $error("spare register reads nonzero");

    a_drv_strength: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $past(drv_reg[csio_pkg::DRV_SPI_BIT])
        |-> primary_output_strong_out == $past(drv_reg[csio_pkg::DRV_STRONG_BIT]))
        else $error("drive strength not taken from register");

    a_drv_format: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        $past(drv_reg[csio_pkg::DRV_SPI_BIT])
        |-> primary_output_fmt_out == $past(drv_reg[5:3]))
        else $error("driver format not taken from register");

    a_pol_cmos: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        ($past(drv_reg[csio_pkg::DRV_SPI_BIT]) && !primary_output_fmt_out[2])
        |-> primary_output_pos_inv_out == $past(drv_reg[2])
            && primary_output_neg_inv_out == !$past(drv_reg[1]))
        else $error("CMOS polarity not applied");

    a_ref_follow: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        !ref_reg[csio_pkg::REF_CRYSTAL_INPUT_BIT] ##1 !ref_reg[csio_pkg::REF_CRYSTAL_INPUT_BIT]
        |-> use_ext_ref_out == $past(ext_ref_sync_reg[1]))
        else $error("detected external reference not followed");

endmodule // csio_config_top

/* bench/csio_host_model.sv */
`timescale 1ns/1ps
module csio_host_model (
    input  wire logic clk_in,
    input  wire logic sdio_in,
    input  wire logic sdio_oe_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdio_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        sdio_out = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge clk_in);
    endtask
    // One frame: read flag, address, one byte, MSB first
    task automatic xfer(input logic rw, input logic [12:0] a, input logic [7:0] wd,
                        output logic [7:0] rdat);
        logic [23:0] f;
        f = {rw, 2'b00, a, wd};
        cs_n_out = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // Released data pin shows a changing pattern
            sdio_out = (rw && i < 8) ? ~sdio_out : f[i];
            half();
            sclk_out = 1'b1;
            if (i < 8) rdat[i] = sdio_oe_in ? sdio_in : 1'bx;
            half();
            sclk_out = 1'b0;
        end
        half();
        cs_n_out = 1'b1;
        half();
    endtask
endmodule // csio_host_model

/* bench/clock_synth_input_output_config_tb.sv */
`timescale 1ns/1ps
module clock_synth_input_output_config_tb;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, output_format_select_pin_in = 1'b1;
    logic ext_ref_present_in = 1'b0, sclk_in, cs_n_in, host_sd, sdio_out, sdio_oe_out;
    wire  sdio_in = sdio_oe_out ? sdio_out : host_sd;
    logic rx_reset_out, bandgap_spi_en_out, crystal_input_cap_auto_out, doubler_sel_out;
    logic use_ext_ref_out, primary_output_strong_out, primary_output_pd_out;
    logic primary_output_pos_en_out, primary_output_neg_en_out;
    logic primary_output_pos_inv_out, primary_output_neg_inv_out;
    logic [4:0] bandgap_code_out;
    logic [5:0] crystal_input_cap_quarter_pf_out;
    logic [2:0] primary_output_fmt_out;
    logic [7:0] rd;
    int fails = 0, n_compared = 0, cyc = 0, n_rst = 0;
    logic [28:0] rows [7] = '{{13'h001a, 8'hff, 8'h7d}, {13'h001b, 8'hff, 8'hbf},
        {13'h001b, 8'h15, 8'h15}, {13'h001c, 8'hff, 8'h00}, {13'h001d, 8'hff, 8'h05},
        {13'h0077, 8'hff, 8'h00}, {13'h0032, 8'hff, 8'hff}};
    wire [8:0] drv = {primary_output_strong_out, primary_output_pd_out, primary_output_fmt_out,
        primary_output_pos_en_out, primary_output_neg_en_out,
        primary_output_pos_inv_out, primary_output_neg_inv_out};
    csio_config_top csio_config_top_inst (.*);
    csio_host_model csio_host_model_inst (.clk_in(clk_sys_in), .sdio_in(sdio_in),
        .sdio_oe_in(sdio_oe_out), .sclk_out(sclk_in), .cs_n_out(cs_n_in), .sdio_out(host_sd));
    always #2.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) begin
        cyc++;
        if (rx_reset_out === 1'b1) n_rst++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        csio_host_model_inst.xfer(1'b0, a, d, rd);
    endtask
    task automatic rdc(input logic [12:0] a, input logic [7:0] e);
        csio_host_model_inst.xfer(1'b1, a, 8'h00, rd);
        chk({1'b0, rd}, {1'b0, e});
    endtask
    task automatic summarize();
        if (fails == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(negedge clk_sys_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_sys_in);
        rdc(13'h001a, 8'h00);
        rdc(13'h001b, 8'h80);
        rdc(13'h001d, 8'h00);
        rdc(13'h0032, 8'ha8);
        chk({2'b00, crystal_input_cap_auto_out, crystal_input_cap_quarter_pf_out}, 9'h07f);
        chk(drv, 9'h15c);
        output_format_select_pin_in = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        chk(drv, 9'h14c);
        output_format_select_pin_in = 1'b1;
        foreach (rows[i]) begin
            wr(rows[i][28:16], rows[i][15:8]);
            rdc(rows[i][28:16], rows[i][7:0]);
        end
        rdc(13'h001b, 8'h15);
        n_rst = 0;
        wr(13'h001a, 8'h80);
        chk(9'(n_rst), 9'h001);
        chk({3'b000, bandgap_spi_en_out, bandgap_code_out}, 9'h000);
        wr(13'h001a, 8'h55);
        chk({3'b000, bandgap_spi_en_out, bandgap_code_out}, 9'h035);
        wr(13'h001b, 8'h15);
        chk({2'b00, crystal_input_cap_auto_out, crystal_input_cap_quarter_pf_out}, 9'h02a);
        ext_ref_present_in = 1'b1;
        wr(13'h001d, 8'h04);
        chk({7'h00, doubler_sel_out, use_ext_ref_out}, 9'h003);
        wr(13'h001d, 8'h01);
        chk({7'h00, doubler_sel_out, use_ext_ref_out}, 9'h000);
        for (int p = 0; p < 4; p++) begin
            wr(13'h0032, {5'b10000, p[1:0], 1'b1});
            chk(drv, {7'b1000011, p[1], ~p[0]});
        end
        for (int f = 0; f < 8; f++) begin
            wr(13'h0032, {2'b01, f[2:0], 3'b101});
            chk(drv, {2'b01, f[2:0], f < 4 ? {~f[1:0], 2'b11} : {~f[1], ~f[1], 2'b00}});
        end
        summarize();
    end
endmodule // clock_synth_input_output_config_tb
